// File: cmb_regs.svh
/*
 * constants of the can message buffering block: buffer layout, fifo sizing,
 * acceptance filter mode codes and the bit levels on the transmit pin.
 * assumes inclusion by its bare name from the package and the design file.
 */
`ifndef CMB_REGS_SVH
`define CMB_REGS_SVH

// bytes in one message buffer (id, control, data)
`define CMB_BUF_BYTES 13
// index width for a byte inside a buffer
`define CMB_IDX_W 4
// words in the receive byte fifo
`define CMB_FIFO_DEPTH 8
// number of transmit buffers
`define CMB_TX_BUFS 3
// width of the local priority field
`define CMB_LOCAL_PRIORITY_W 8
// acceptance filter modes
`define CMB_FLT_ONE32 2'h0
`define CMB_FLT_TWO16 2'h1
`define CMB_FLT_FOUR8 2'h2
`define CMB_FLT_CLOSED 2'h3
// levels on the transmit pin
`define CMB_DOMINANT 1'h0
`define CMB_RECESSIVE 1'h1
// flag bit positions in the data byte of an end-of-frame word
`define CMB_END_OK_BIT 0
`define CMB_END_OWN_BIT 1

`endif

// File: cmb_pkg.sv
/*
 * types of the can message buffering block.
 * assumes cmb_regs.svh is on the include path.
 */
`include "cmb_regs.svh"

package cmb_pkg;
	// one message buffer of bytes
	typedef logic [`CMB_BUF_BYTES-1:0][7:0] cmb_buf_t;
	// word passed from protocol engine through the receive fifo
	typedef struct packed {
		logic last; // end-of-frame marker, data holds flags
		logic [`CMB_IDX_W-1:0] idx; // byte position in buffer
		logic [7:0] data; // received byte
	} cmb_rxword_s;
	// cpu write into a transmit buffer
	typedef struct packed {
		logic en; // write strobe
		logic local_priority; // write goes to priority field
		logic [1:0] sel; // buffer number
		logic [`CMB_IDX_W-1:0] idx; // byte position
		logic [7:0] data; // byte value
	} cmb_txwr_s;
	// whole state of the buffering core
	typedef struct packed {
		logic txPin;
		logic rxBit;
		cmb_buf_t back;
		cmb_buf_t front;
		logic rxFull;
		logic backHeld;
		logic [7:0] readData;
		logic rxIrq;
		logic overrunIrq;
		logic [1:0] idHit;
		logic [`CMB_TX_BUFS-1:0] txEmpty;
		logic [`CMB_TX_BUFS-1:0][`CMB_LOCAL_PRIORITY_W-1:0] local_priority;
		logic [`CMB_TX_BUFS-1:0] txBufValid;
		cmb_buf_t txBuf0;
		cmb_buf_t txBuf1;
		cmb_buf_t txBuf2;
		logic [1:0] txSel;
		logic txActive;
		logic txRequest;
		logic [7:0] txRdData;
	} cmb_state_s;
endpackage : cmb_pkg

// File: cmb_buffering.sv
/*
 * can message buffering: receive byte fifo, ping-pong receive store with
 * acceptance filter, three prioritised transmit buffers, pin stage.
 * assumes a protocol engine beside it that shifts bits, delivers received
 * bytes with an end marker, and fetches transmit bytes by index.
 */
`timescale 1ns/1ps
`include "cmb_regs.svh"

// fifo with valid/ready on both ends; pointers carry a wrap bit
module cmb_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = `CMB_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
	logic [AW:0] wrPtr; // write pointer with wrap bit
	logic [AW:0] rdPtr; // read pointer with wrap bit
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign empty = (wrPtr == rdPtr);
	assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	assign inReady = !full && ce;
	assign outValid = !empty;
	assign outData = mem[rdPtr[AW-1:0]];
	assign push = inValid && inReady;
	assign pop = outValid && outReady && ce;

	// pointer and storage update
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrPtr <= '0;
			rdPtr <= '0;
			mem <= '0;
		end else begin
			if (push) begin
				mem[wrPtr[AW-1:0]] <= inData;
				wrPtr <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end
endmodule : cmb_fifo

module cmb_buffering (
	// clock, reset, freeze
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// can transceiver pins
	input wire logic serial_rx_in,
	output logic serial_tx_out,
	// protocol engine bit path
	input wire logic engineTxBit,
	output logic engineRxBit,
	input wire logic loopBack,
	// protocol engine received bytes
	input wire cmb_pkg::cmb_rxword_s rxWord,
	input wire logic rxWordValid,
	output logic rxWordReady,
	// protocol engine transmit fetch
	input wire logic txArbStart,
	input wire logic txDone,
	input wire logic [`CMB_IDX_W-1:0] txRdIdx,
	output logic [7:0] txRdData,
	output logic [1:0] txSel,
	output logic txRequest,
	// acceptance filter setup
	input wire logic [1:0] filterMode,
	input wire logic [31:0] acceptCode,
	input wire logic [31:0] acceptMask,
	// cpu receive side
	input wire logic [`CMB_IDX_W-1:0] rxRdIdx,
	output logic [7:0] rxRdData,
	input wire logic rxFlagClear,
	output logic rx_full_flag,
	output logic [1:0] idHit,
	input wire logic overrunEnable,
	output logic rxIrq,
	output logic overrunIrq,
	// cpu transmit side
	input wire cmb_pkg::cmb_txwr_s txWr,
	input wire logic [`CMB_TX_BUFS-1:0] txReadySet,
	output logic [`CMB_TX_BUFS-1:0] tx_empty_flag
);
	cmb_pkg::cmb_state_s st; // registered state
	cmb_pkg::cmb_state_s next_st; // next state
	cmb_pkg::cmb_rxword_s popWord; // fifo head
	logic popValid; // fifo holds a word
	logic popReady; // core takes the head this cycle
	logic [3:0] hit8; // per-byte filter matches
	logic hit16a; // upper 16-bit filter
	logic hit16b; // lower 16-bit filter
	logic hit32; // full 32-bit filter
	logic accept; // current back frame passes filter
	logic [1:0] hitNum; // lowest matching filter

	// receive bytes pass through the fifo; a stall here reaches the engine
	cmb_fifo #(
		.WIDTH($bits(cmb_pkg::cmb_rxword_s)),
		.DEPTH(`CMB_FIFO_DEPTH)
	) u_rxFifo (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.inValid(rxWordValid),
		.inReady(rxWordReady),
		.inData(rxWord),
		.outValid(popValid),
		.outReady(popReady),
		.outData(popWord)
	);

	// hold the head while a cpu clear is in flight, so clear and frame end never race
	assign popReady = !rxFlagClear;

	// four byte filters on the first identifier byte, mask bit set means ignore
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flt8
			assign hit8[gi] = &(~(st.back[0] ^ acceptCode[31-8*gi -: 8])
				| acceptMask[31-8*gi -: 8]);
		end
	endgenerate
	assign hit16a = &(~({st.back[0], st.back[1]} ^ acceptCode[31:16]) | acceptMask[31:16]);
	assign hit16b = &(~({st.back[0], st.back[1]} ^ acceptCode[15:0]) | acceptMask[15:0]);
	assign hit32 = &(~({st.back[0], st.back[1], st.back[2], st.back[3]} ^ acceptCode)
		| acceptMask);

	// filter mode select, lower filter number wins a multiple hit
	always_comb begin
		accept = 1'b0;
		hitNum = 2'h0;
		case (filterMode)
			`CMB_FLT_ONE32: begin
				accept = hit32;
			end
			`CMB_FLT_TWO16: begin
				accept = hit16a | hit16b;
				hitNum = hit16a ? 2'h0 : 2'h1;
			end
			`CMB_FLT_FOUR8: begin
				accept = |hit8;
				hitNum = hit8[0] ? 2'h0 : hit8[1] ? 2'h1 : hit8[2] ? 2'h2 : 2'h3;
			end
			default: begin
				accept = 1'b0; // closed: nothing reaches the front buffer
			end
		endcase
	end

	// next-state logic for pins, receive store and transmit buffers
	always_comb begin
		logic endOk;
		logic endOwn;
		logic [`CMB_LOCAL_PRIORITY_W-1:0] bestPrio;
		logic bestFound;
		next_st = st;
		endOk = popWord.data[`CMB_END_OK_BIT];
		endOwn = popWord.data[`CMB_END_OWN_BIT];
		bestPrio = '1;
		bestFound = 1'b0;
		next_st.rxIrq = 1'b0;
		next_st.overrunIrq = 1'b0;
		// pin stage; loop-back keeps the bus recessive and feeds tx back to rx
		next_st.txPin = loopBack ? `CMB_RECESSIVE : engineTxBit;
		next_st.rxBit = loopBack ? engineTxBit : serial_rx_in;
		// cpu clear releases the front; a held back frame moves up at once
		if (rxFlagClear) begin
			next_st.rxFull = 1'b0;
			if (st.backHeld) begin
				next_st.front = st.back;
				next_st.rxFull = 1'b1;
				next_st.backHeld = 1'b0;
				next_st.rxIrq = 1'b1;
			end
		end
		// drain one fifo word into the back buffer or finish a frame
		if (popValid && popReady) begin
			if (!popWord.last) begin
				// back buffer always overwritten unless it holds a waiting frame
				if (!st.backHeld && popWord.idx < `CMB_IDX_W'(`CMB_BUF_BYTES)) begin
					next_st.back[popWord.idx] = popWord.data;
				end
			end else if (endOk && accept && (!endOwn || loopBack) && !st.backHeld) begin
				// own frames only count in loop-back; a lost arbitration arrives as foreign
				if (!st.rxFull) begin
					next_st.front = st.back;
					next_st.rxFull = 1'b1;
					next_st.idHit = hitNum;
					next_st.rxIrq = 1'b1;
				end else begin
					next_st.backHeld = 1'b1; // second stage now occupied
				end
			end else if (endOk && accept && (!endOwn || loopBack)) begin
				// both stages full: newest accepted frame dropped
				next_st.overrunIrq = overrunEnable;
			end
			// errored, rejected or own frames fall through untouched
		end
		// cpu reads only the front buffer
		next_st.readData = (rxRdIdx < `CMB_IDX_W'(`CMB_BUF_BYTES)) ? st.front[rxRdIdx] : 8'h00;
		// cpu loads transmit buffers
		if (txWr.en && txWr.sel < 2'h3) begin
			if (txWr.local_priority) begin
				next_st.local_priority[txWr.sel] = txWr.data;
			end else if (txWr.idx < `CMB_IDX_W'(`CMB_BUF_BYTES)) begin
				case (txWr.sel)
					2'h0: next_st.txBuf0[txWr.idx] = txWr.data;
					2'h1: next_st.txBuf1[txWr.idx] = txWr.data;
					default: next_st.txBuf2[txWr.idx] = txWr.data;
				endcase
			end
		end
		// clearing an empty flag queues the buffer
		next_st.txEmpty = st.txEmpty & ~txReadySet;
		// completion frees the selected buffer; set wins over a same-cycle clear
		if (txDone && st.txActive) begin
			next_st.txEmpty[st.txSel] = 1'b1;
			next_st.txActive = 1'b0;
		end
		// schedule at every arbitration start: lowest priority value first
		if (txArbStart) begin
			next_st.txActive = 1'b0;
			for (int i = 0; i < `CMB_TX_BUFS; i++) begin
				if (!st.txEmpty[i] && (!bestFound || st.local_priority[i] < bestPrio)) begin
					bestFound = 1'b1;
					bestPrio = st.local_priority[i];
					next_st.txSel = 2'(i);
				end
			end
			next_st.txActive = bestFound;
		end
		// keep contending while anything is queued; transmit unaffected by rx state
		next_st.txRequest = |(~next_st.txEmpty);
		// byte fetch for the engine from the selected buffer
		case (st.txSel)
			2'h0: next_st.txRdData = st.txBuf0[txRdIdx % `CMB_BUF_BYTES];
			2'h1: next_st.txRdData = st.txBuf1[txRdIdx % `CMB_BUF_BYTES];
			default: next_st.txRdData = st.txBuf2[txRdIdx % `CMB_BUF_BYTES];
		endcase
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '0;
			st.txPin <= `CMB_RECESSIVE;
			st.rxBit <= `CMB_RECESSIVE;
			st.txEmpty <= '1;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign serial_tx_out = st.txPin;
	assign engineRxBit = st.rxBit;
	assign rxRdData = st.readData;
	assign rx_full_flag = st.rxFull;
	assign idHit = st.idHit;
	assign rxIrq = st.rxIrq;
	assign overrunIrq = st.overrunIrq;
	assign tx_empty_flag = st.txEmpty;
	assign txSel = st.txSel;
	assign txRequest = st.txRequest;
	assign txRdData = st.txRdData;

	// frame-level protocol timing (bit rate, frame types, lengths) lives in the engine

	// receive interrupt only ever with the full flag set
	rx_irq_full_a: assert property (@(posedge clk) disable iff (reset)
		rxIrq |-> rx_full_flag)
		else $error("receive interrupt without full flag");

	// loop-back keeps the bus recessive one cycle later
	loop_pin_a: assert property (@(posedge clk) disable iff (reset)
		(ce && loopBack) |=> (serial_tx_out == `CMB_RECESSIVE))
		else $error("bus driven during loop-back");

	// normal mode mirrors the engine bit
	tx_pin_a: assert property (@(posedge clk) disable iff (reset)
		(ce && !loopBack) |=> (serial_tx_out == $past(engineTxBit)))
		else $error("transmit pin does not follow engine");

	// held frame never exists without a full front
	held_front_a: assert property (@(posedge clk) disable iff (reset)
		st.backHeld |-> rx_full_flag)
		else $error("back frame held with empty front");

	// overrun only while both stages full
	overrun_full_a: assert property (@(posedge clk) disable iff (reset)
		overrunIrq |-> ($past(st.backHeld) && rx_full_flag))
		else $error("overrun with free stage");

	// front changes only on a copy event
	front_stable_a: assert property (@(posedge clk) disable iff (reset)
		(st.front != $past(st.front)) |-> (rxIrq))
		else $error("front buffer changed without copy");

	// own frame outside loop-back never raises a receive interrupt
	own_quiet_a: assert property (@(posedge clk) disable iff (reset)
		(ce && popValid && popReady && popWord.last && popWord.data[`CMB_END_OWN_BIT]
		&& !loopBack && !rxFlagClear) |=> !rxIrq)
		else $error("own frame raised receive interrupt");

	// request follows the empty flags
	tx_request_a: assert property (@(posedge clk) disable iff (reset)
		txRequest == !(&tx_empty_flag))
		else $error("bus request mismatches queue");

	// chosen buffer pending and not beaten by a lower priority value
	tx_local_priority_a: assert property (@(posedge clk) disable iff (reset)
		(ce && txArbStart && !(&tx_empty_flag) && !txWr.en && !txDone && txReadySet == '0)
		|=> (!tx_empty_flag[txSel] && (tx_empty_flag[0] || st.local_priority[0] >= st.local_priority[txSel])
		&& (tx_empty_flag[1] || st.local_priority[1] >= st.local_priority[txSel])
		&& (tx_empty_flag[2] || st.local_priority[2] >= st.local_priority[txSel])))
		else $error("lower priority buffer selected");
endmodule : cmb_buffering

// File: cmb_transceiver_model.sv
/*
 * behavioural can transceiver for the buffering bench: wired-and bus line.
 * assumes the controller's transmit pin and one far node share the bus.
 */
`timescale 1ns/1ps

module cmb_transceiver_model (
	// controller transmit pin
	input wire logic txPin,
	// far node pulls the bus dominant when high
	input wire logic remoteDominant,
	// receive pin back to the controller
	output logic rxPin
);
	// any dominant (0) wins; the bus idles recessive (1) when nobody drives
	assign rxPin = txPin & ~remoteDominant;
endmodule : cmb_transceiver_model

// File: testbench.sv
/*
 * self-checking bench for cmb_buffering: frames into the receive fifo,
 * cpu reads and flag clears, transmit scheduling, pin levels.
 * assumes cmb_pkg, cmb_regs.svh and the transceiver model are compiled first.
 */
`timescale 1ns/1ps
`include "cmb_regs.svh"

module testbench;
	// bench signals, named after the ports they feed
	logic clk, reset, ce, serialRx, serialTx, remoteDominant, engineTxBit, engineRxBit;
	logic loopBack, rxWordValid, rxWordReady, txArbStart, txDone, txRequest;
	logic rxFlagClear, rxFullFlag, overrunEnable, rxIrq, overrunIrq;
	logic [`CMB_IDX_W-1:0] txRdIdx, rxRdIdx;
	logic [7:0] txRdData, rxRdData;
	logic [1:0] txSel, filterMode, idHit;
	logic [31:0] acceptCode, acceptMask;
	logic [2:0] txReadySet, txEmptyFlag;
	cmb_pkg::cmb_rxword_s rxWord;
	cmb_pkg::cmb_txwr_s txWr;
	int fails;
	int testsRun;

	// device under test
	cmb_buffering dut_u (.clk(clk), .reset(reset), .ce(ce), .serial_rx_in(serialRx),
		.serial_tx_out(serialTx), .engineTxBit(engineTxBit), .engineRxBit(engineRxBit),
		.loopBack(loopBack), .rxWord(rxWord), .rxWordValid(rxWordValid),
		.rxWordReady(rxWordReady), .txArbStart(txArbStart), .txDone(txDone),
		.txRdIdx(txRdIdx), .txRdData(txRdData), .txSel(txSel), .txRequest(txRequest),
		.filterMode(filterMode), .acceptCode(acceptCode), .acceptMask(acceptMask),
		.rxRdIdx(rxRdIdx), .rxRdData(rxRdData), .rxFlagClear(rxFlagClear),
		.rx_full_flag(rxFullFlag), .idHit(idHit), .overrunEnable(overrunEnable),
		.rxIrq(rxIrq), .overrunIrq(overrunIrq), .txWr(txWr), .txReadySet(txReadySet),
		.tx_empty_flag(txEmptyFlag));

	// far side of the bus
	cmb_transceiver_model bus_u (.txPin(serialTx), .remoteDominant(remoteDominant),
		.rxPin(serialRx));

	// free-running 250 MHz clock
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	// verdict and end of run, the only exit
	task automatic finish_test;
		$display("tests_run %0d fails %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	// one comparison; four-state so an unknown never matches
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// bounded wait ran out: counted, then straight to the verdict
	task automatic timeout(input string what);
		fails++;
		$display("[ERR] %s expected handshake seen timeout", what);
		finish_test();
	endtask : timeout

	// every input moves 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// one word into the fifo; held until an edge sees ready high
	task automatic push(input logic last, input logic [3:0] idx, input logic [7:0] data);
		int guard = 0;
		rxWord = '{last: last, idx: idx, data: data};
		rxWordValid = 1'h1;
		while (rxWordReady !== 1'h1 && guard < 50) begin
			tick(1);
			guard++;
		end
		if (guard == 50) timeout("rxWordReady");
		tick(1);
	endtask : push

	// whole 13-byte frame with counting payload, then the end word
	task automatic frame(input logic [7:0] b0, input logic ok, input logic own);
		for (int i = 0; i < `CMB_BUF_BYTES; i++) push(1'h0, 4'(i), b0 + 8'(i));
		push(1'h1, 4'h0, {6'h00, own, ok});
		rxWordValid = 1'h0;
	endtask : frame

	// watch a one-cycle interrupt pulse for 40 cycles
	task automatic waitIrq(input logic over, input logic want, input string what);
		logic seen = 1'h0;
		for (int i = 0; i < 40 && seen !== 1'h1; i++) begin
			tick(1);
			seen = over ? overrunIrq : rxIrq;
		end
		if (want && seen !== 1'h1) timeout(what);
		check(what, want, seen);
	endtask : waitIrq

	// cpu read of the front buffer, data one cycle after the index
	task automatic readRx(input logic [3:0] idx, input logic [7:0] exp);
		rxRdIdx = idx;
		tick(1);
		check("rxRdData", exp, rxRdData);
	endtask : readRx

	// cpu clears the full flag, leaves us just after the taking edge
	task automatic clearFlag;
		rxFlagClear = 1'h1;
		tick(1);
		rxFlagClear = 1'h0;
	endtask : clearFlag

	// one filter mode: exact code, no don't-care bits
	task automatic filt(input logic [1:0] m, input logic [31:0] code, input logic [7:0] b0,
		input logic acc, input logic [1:0] hit);
		filterMode = m;
		acceptCode = code;
		acceptMask = 32'h00000000;
		frame(b0, 1'h1, 1'h0);
		waitIrq(1'h0, acc, "rxIrq");
		check("rxFull", acc, rxFullFlag);
		if (acc) begin
			check("idHit", hit, idHit);
			readRx(4'h0, b0);
			clearFlag();
		end
	endtask : filt

	// cpu write into a transmit buffer, byte 0 or priority; strobe stays up,
	// the caller drops it after the last write so it never toggles in one step
	task automatic txWrite(input logic pr, input logic [1:0] sel, input logic [7:0] data);
		txWr = '{en: 1'h1, local_priority: pr, sel: sel, idx: 4'h0, data: data};
		tick(1);
	endtask : txWrite

	// arbitration round: pick, fetch byte 0, report sent
	task automatic arb(input logic [1:0] expSel, input logic [7:0] expByte);
		txArbStart = 1'h1;
		tick(1);
		txArbStart = 1'h0;
		check("txSel", expSel, txSel);
		tick(1);
		check("txRdData", expByte, txRdData);
		txDone = 1'h1;
		tick(1);
		txDone = 1'h0;
		check("txEmpty", 1'h1, txEmptyFlag[expSel]);
	endtask : arb

	// main sequence
	initial begin
		fails = 0;
		testsRun = 0;
		reset = 1'h1;
		ce = 1'h1;
		remoteDominant = 1'h0;
		engineTxBit = 1'h1;
		loopBack = 1'h0;
		rxWord = '0;
		rxWordValid = 1'h0;
		txArbStart = 1'h0;
		txDone = 1'h0;
		txRdIdx = 4'h0;
		rxRdIdx = 4'h0;
		filterMode = `CMB_FLT_ONE32;
		acceptCode = 32'h00000000;
		acceptMask = 32'h00000000;
		rxFlagClear = 1'h0;
		overrunEnable = 1'h0;
		txWr = '0;
		txReadySet = 3'h0;
		tick(4);
		reset = 1'h0;
		check("serialTx", 1'h1, serialTx);
		check("txEmpty", 3'h7, txEmptyFlag);
		check("rxFull", 1'h0, rxFullFlag);
		$display("test reset done");
		// pins: dominant out, far node dominance seen on receive
		engineTxBit = 1'h0;
		tick(1);
		check("serialTx", 1'h0, serialTx);
		tick(1);
		check("engineRxBit", 1'h0, engineRxBit);
		engineTxBit = 1'h1;
		remoteDominant = 1'h1;
		tick(3);
		check("engineRxBit", 1'h0, engineRxBit);
		remoteDominant = 1'h0;
		ce = 1'h0;
		tick(1);
		check("rxWordReady", 1'h0, rxWordReady);
		check("engineRxBit", 1'h0, engineRxBit);
		ce = 1'h1;
		tick(2);
		check("engineRxBit", 1'h1, engineRxBit);
		$display("test pins done");
		// every filter mode, closed one refuses all
		filt(`CMB_FLT_ONE32, 32'h40414243, 8'h40, 1'h1, 2'h0);
		filt(`CMB_FLT_TWO16, 32'hFFFF5051, 8'h50, 1'h1, 2'h1);
		filt(`CMB_FLT_FOUR8, 32'h11223344, 8'h33, 1'h1, 2'h2);
		filt(`CMB_FLT_CLOSED, 32'h60616263, 8'h60, 1'h0, 2'h0);
		$display("test filters done");
		// accept everything from here on
		filterMode = `CMB_FLT_ONE32;
		acceptMask = 32'hFFFFFFFF;
		frame(8'h70, 1'h0, 1'h0);
		waitIrq(1'h0, 1'h0, "rxIrq");
		frame(8'h71, 1'h1, 1'h1);
		waitIrq(1'h0, 1'h0, "rxIrq");
		check("rxFull", 1'h0, rxFullFlag);
		loopBack = 1'h1;
		engineTxBit = 1'h0;
		tick(2);
		check("serialTx", 1'h1, serialTx);
		engineTxBit = 1'h1;
		frame(8'h72, 1'h1, 1'h1);
		waitIrq(1'h0, 1'h1, "rxIrq");
		readRx(4'h0, 8'h72);
		loopBack = 1'h0;
		clearFlag();
		tick(1);
		check("rxFull", 1'h0, rxFullFlag);
		$display("test own frames done");
		// back-to-back frames: front, held, then overrun
		overrunEnable = 1'h1;
		frame(8'h80, 1'h1, 1'h0);
		waitIrq(1'h0, 1'h1, "rxIrq");
		frame(8'h90, 1'h1, 1'h0);
		waitIrq(1'h0, 1'h0, "rxIrq");
		frame(8'hA0, 1'h1, 1'h0);
		waitIrq(1'h1, 1'h1, "overrunIrq");
		readRx(4'h1, 8'h81);
		clearFlag();
		check("rxFull", 1'h1, rxFullFlag);
		check("rxIrq", 1'h1, rxIrq);
		readRx(4'hC, 8'h9C);
		clearFlag();
		tick(1);
		check("rxFull", 1'h0, rxFullFlag);
		$display("test overrun done");
		// three buffers, priority 5/3/3: tie goes to the lower number
		txWrite(1'h1, 2'h0, 8'h05);
		txWrite(1'h1, 2'h1, 8'h03);
		txWrite(1'h1, 2'h2, 8'h03);
		for (int b = 0; b < 3; b++) txWrite(1'h0, 2'(b), 8'hA0 + 8'(b));
		txWr.en = 1'h0;
		check("txEmpty", 3'h7, txEmptyFlag);
		txReadySet = 3'h7;
		tick(1);
		txReadySet = 3'h0;
		check("txEmpty", 3'h0, txEmptyFlag);
		tick(1);
		check("txRequest", 1'h1, txRequest);
		arb(2'h1, 8'hA1);
		arb(2'h2, 8'hA2);
		arb(2'h0, 8'hA0);
		tick(1);
		check("txRequest", 1'h0, txRequest);
		$display("test transmit done");
		finish_test();
	end
endmodule : testbench
